// [hw/frps_pkg.sv]
// constants and carrier types of the flash reset and power sequencer
package frps_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // --------------------------------------------------------------
    // timing figures as printed
    // --------------------------------------------------------------
    localparam int unsigned POWER_UP_DELAY_US = 300;
    localparam int unsigned RESET_PULSE_HOLD_TIME_US = 35;
    localparam int unsigned RESET_PULSE_WIDTH_NS = 200;
    localparam int unsigned RESET_HOLD_BEFORE_SELECT_NS = 50;
    localparam int unsigned RESET_SETUP_TIME_NS = 50;
    // --------------------------------------------------------------
    // cycle counts, least times rounded up
    // --------------------------------------------------------------
    localparam int unsigned POWER_UP_CYC = POWER_UP_DELAY_US * CLK_MHZ;
    localparam int unsigned RESET_HOLD_CYC = RESET_PULSE_HOLD_TIME_US * CLK_MHZ;
    localparam int unsigned PULSE_WIDTH_CYC = (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SEL_HOLD_CYC = (RESET_HOLD_BEFORE_SELECT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

    typedef enum logic [2:0]
    {
        FRPS_POWER_ON = 3'b000,
        FRPS_STANDBY = 3'b001,
        FRPS_ACTIVE = 3'b010,
        FRPS_RESET_WAIT = 3'b011,
        FRPS_RESET_HOLD = 3'b100,
        FRPS_SEL_HOLD = 3'b101
    } frps_state_e;

    // status carried to the core
    typedef struct packed
    {
        logic select_enable;
        logic active_power;
        logic standby_power;
        logic reset_busy;
        logic outputs_tristate;
        logic abort_ops;
        logic iface_to_standby;
        logic init_done;
    } frps_status_s;
endpackage

// [hw/frps_sequencer.sv]
// reset and power-mode sequencer for a serial nor flash
`timescale 1ns/1ps
// Summary of operation
// - chip select low enables device in active mode; high blocks new commands
// - after select rises, stay active until pending operations finish, then standby
// - power-on initialization runs the full power-up delay from supply good
// - warm-reset input ignored while power-on initialization runs
// - warm reset resets register state like power-on, without full process
// - hardware reset takes the reset pulse hold period before select accepted
// - failed power-on init: warm reset runs the full power-up delay
// - reset low for pulse width aborts, tri-states outputs, masks commands
// - hardware reset returns the serial interface machine to standby
// - reset asserted at power-up end keeps device in reset until hold
module frps_sequencer #(
    parameter int unsigned POWER_UP_CYCLES = frps_pkg::POWER_UP_CYC,
    parameter int unsigned RESET_HOLD_CYCLES = frps_pkg::RESET_HOLD_CYC
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // supply monitor and pins
    input wire logic supply_good,
    input wire logic chip_select_n,
    input wire logic warm_reset_n,
    input wire logic serial_clk,
    // core handshake
    input wire logic ops_pending,
    input wire logic init_ok,
    // status and control to core
    output frps_pkg::frps_status_s status,
    output logic reg_reset_pulse,
    output logic serial_clk_edge
);
    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // refused at elaboration: zero power-up count, reset hold not above the pulse width, or loads too wide for the counter
    if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES >= (1 << frps_pkg::CNT_W))
    begin : g_bad_power_up
        $error("power up count out of range");
    end
    if (RESET_HOLD_CYCLES <= frps_pkg::PULSE_WIDTH_CYC ||
        RESET_HOLD_CYCLES >= (1 << frps_pkg::CNT_W))
    begin : g_bad_reset_hold
        $error("reset hold count out of range");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic cs_n_s;
    logic rst_n_s;
    logic sup_s;
    logic sck_s;
    logic sck_d;
    assign cs_n_s = sync_b[0];
    assign rst_n_s = sync_b[1];
    assign sup_s = sync_b[2];

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sync_a <= 3'h3;
            sync_b <= 3'h3;
        end
        else if (clk_en)
        begin
            sync_a <= {supply_good, warm_reset_n, chip_select_n};
            sync_b <= sync_a;
        end
    end

    // serial clock sampled only for edge reporting; timing never relies on it
    logic sck_a;
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sck_a <= 1'b0;
            sck_s <= 1'b0;
            sck_d <= 1'b0;
        end
        else if (clk_en)
        begin
            sck_a <= serial_clk;
            sck_s <= sck_a;
            sck_d <= sck_s;
        end
    end
    assign serial_clk_edge = sck_s & ~sck_d;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    frps_pkg::frps_state_e state;
    frps_pkg::frps_state_e next_state;
    logic [frps_pkg::CNT_W-1:0] cnt;
    logic [frps_pkg::CNT_W-1:0] next_cnt;
    logic [frps_pkg::CNT_W-1:0] low_cnt;
    logic init_good;
    logic next_init_good;
    logic cnt_done;
    logic reset_qualified;
    logic supply_lost;

    localparam logic [frps_pkg::CNT_W-1:0] PU_LOAD = POWER_UP_CYCLES[frps_pkg::CNT_W-1:0];
    localparam logic [frps_pkg::CNT_W-1:0] RH_LOAD = RESET_HOLD_CYCLES[frps_pkg::CNT_W-1:0];
    localparam logic [frps_pkg::CNT_W-1:0] PW_LOAD =
        frps_pkg::PULSE_WIDTH_CYC[frps_pkg::CNT_W-1:0];
    localparam logic [frps_pkg::CNT_W-1:0] SH_LOAD =
        frps_pkg::SEL_HOLD_CYC[frps_pkg::CNT_W-1:0];

    assign cnt_done = (cnt == frps_pkg::CNT_ONE) || (cnt == frps_pkg::CNT_ZERO);
    // short glitches on the reset pin are filtered by the pulse-width count
    assign reset_qualified = (low_cnt >= PW_LOAD);
    assign supply_lost = ~sup_s;

    // reset pin low-time counter, saturating
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            low_cnt <= frps_pkg::CNT_ZERO;
        else if (clk_en)
        begin
            if (rst_n_s)
                low_cnt <= frps_pkg::CNT_ZERO;
            else if (!reset_qualified)
                low_cnt <= low_cnt + frps_pkg::CNT_ONE;
        end
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_init_good = init_good;
        if (cnt != frps_pkg::CNT_ZERO)
            next_cnt = cnt - frps_pkg::CNT_ONE;
        case (state)
            frps_pkg::FRPS_POWER_ON:
            begin
                // reset pin is not looked at while powering on
                if (!sup_s)
                    next_cnt = PU_LOAD;
                else if (cnt_done)
                begin
                    next_init_good = init_ok;
                    if (!rst_n_s)
                    begin
                        next_state = frps_pkg::FRPS_RESET_WAIT;
                    end
                    else
                        next_state = frps_pkg::FRPS_STANDBY;
                end
            end
            frps_pkg::FRPS_STANDBY, frps_pkg::FRPS_ACTIVE:
            begin
                if (reset_qualified)
                begin
                    if (!init_good)
                    begin
                        next_state = frps_pkg::FRPS_POWER_ON;
                        next_cnt = PU_LOAD;
                    end
                    else
                    begin
                        next_state = frps_pkg::FRPS_RESET_HOLD;
                        next_cnt = RH_LOAD - PW_LOAD;
                    end
                end
                else if (!cs_n_s)
                    next_state = frps_pkg::FRPS_ACTIVE;
                else if (!ops_pending)
                    next_state = frps_pkg::FRPS_STANDBY;
                else
                    next_state = frps_pkg::FRPS_ACTIVE;
            end
            frps_pkg::FRPS_RESET_HOLD:
            begin
                if (cnt_done && rst_n_s)
                begin
                    next_state = frps_pkg::FRPS_SEL_HOLD;
                    next_cnt = SH_LOAD;
                end
                else if (cnt_done)
                    next_state = frps_pkg::FRPS_RESET_WAIT;
            end
            frps_pkg::FRPS_RESET_WAIT:
            begin
                // stays in reset while the pin is held low
                if (rst_n_s)
                begin
                    next_state = frps_pkg::FRPS_SEL_HOLD;
                    next_cnt = SH_LOAD;
                end
            end
            frps_pkg::FRPS_SEL_HOLD:
            begin
                if (!rst_n_s)
                    next_state = frps_pkg::FRPS_RESET_WAIT;
                else if (cnt_done)
                    next_state = frps_pkg::FRPS_STANDBY;
            end
            default:
            begin
                next_state = frps_pkg::FRPS_POWER_ON;
                next_cnt = PU_LOAD;
            end
        endcase
        // losing supply restarts the full power-on process
        if (supply_lost && state != frps_pkg::FRPS_POWER_ON)
        begin
            next_state = frps_pkg::FRPS_POWER_ON;
            next_cnt = PU_LOAD;
            next_init_good = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state <= frps_pkg::FRPS_POWER_ON;
            cnt <= PU_LOAD;
            init_good <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            cnt <= next_cnt;
            init_good <= next_init_good;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic in_reset;
    logic entering_reset;
    frps_pkg::frps_status_s next_status;
    assign in_reset = (state == frps_pkg::FRPS_POWER_ON) ||
                      (state == frps_pkg::FRPS_RESET_HOLD) ||
                      (state == frps_pkg::FRPS_RESET_WAIT) ||
                      (state == frps_pkg::FRPS_SEL_HOLD);
    assign entering_reset = (next_state == frps_pkg::FRPS_RESET_HOLD) &&
                            (state != frps_pkg::FRPS_RESET_HOLD);

    always_comb
    begin
        next_status.select_enable = (next_state == frps_pkg::FRPS_ACTIVE) && !cs_n_s;
        next_status.active_power = (next_state == frps_pkg::FRPS_ACTIVE);
        next_status.standby_power = (next_state == frps_pkg::FRPS_STANDBY);
        next_status.reset_busy = (next_state != frps_pkg::FRPS_ACTIVE) &&
                                 (next_state != frps_pkg::FRPS_STANDBY);
        next_status.outputs_tristate = next_status.reset_busy;
        next_status.abort_ops = next_status.reset_busy && !in_reset;
        next_status.iface_to_standby = next_status.reset_busy;
        next_status.init_done = next_init_good;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            status <= 8'h18;
            reg_reset_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            status <= next_status;
            reg_reset_pulse <= entering_reset;
        end
    end
endmodule // frps_sequencer

// [bench/frps_props.sv]
// assertion checker of the flash reset and power sequencer
`timescale 1ns/1ps
module frps_props #(
    parameter int unsigned POWER_UP_CYCLES = 50,
    parameter int unsigned RESET_HOLD_CYCLES = 100
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // pins and core inputs
    input wire logic supply_good,
    input wire logic chip_select_n,
    input wire logic warm_reset_n,
    input wire logic serial_clk,
    input wire logic ops_pending,
    input wire logic init_ok,
    // observed outputs
    input wire frps_pkg::frps_status_s status,
    input wire logic reg_reset_pulse,
    input wire logic serial_clk_edge
);
    // ----------------------------------------
    // helper counters, saturating
    // ----------------------------------------
    logic [15:0] up_cnt;
    logic [15:0] hi_cnt;
    logic [15:0] rst_cnt;
    always_ff @(posedge core_clk)
    begin
        up_cnt <= (!resetn || !supply_good) ? 16'h0000 : up_cnt + 16'(up_cnt != 16'hffff);
        hi_cnt <= warm_reset_n ? hi_cnt + 16'(hi_cnt != 16'hffff) : 16'h0000;
        rst_cnt <= !resetn ? 16'hffff : reg_reset_pulse ? 16'h0000
            : rst_cnt + 16'(rst_cnt != 16'hffff);
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sel_mask_a: assert property (status.reset_busy |-> !status.select_enable)
        else $error("select enabled during reset");
    tri_state_a: assert property (status.reset_busy |-> status.outputs_tristate)
        else $error("outputs driven during reset");
    abort_pulse_a: assert property (status.abort_ops |=> !status.abort_ops)
        else $error("abort longer than one cycle");
    reg_pulse_a: assert property (reg_reset_pulse |-> status.reset_busy && status.abort_ops)
        else $error("register reset outside reset entry");
    power_excl_a: assert property (!(status.active_power && status.standby_power))
        else $error("active and standby together");
    pending_active_a: assert property (status.active_power && ops_pending && chip_select_n
        |=> !status.standby_power)
        else $error("standby with work pending");
    select_active_a: assert property ((!chip_select_n && !status.reset_busy) [*5]
        |-> status.active_power && status.select_enable)
        else $error("selected device not active");
    up_count_a: assert property ($rose(status.init_done) |-> up_cnt >= POWER_UP_CYCLES)
        else $error("power-up ended early");
    warm_gate_a: assert property (reg_reset_pulse |-> up_cnt >= POWER_UP_CYCLES)
        else $error("warm reset taken during power-up");
    hold_time_a: assert property ($fell(status.reset_busy)
        |-> rst_cnt >= RESET_HOLD_CYCLES - 40)
        else $error("reset hold too short");
    sel_hold_a: assert property ($fell(status.reset_busy) |-> hi_cnt >= 10)
        else $error("select hold too short");
    cover property (reg_reset_pulse);
    cover property (status.active_power);
    cover property ($fell(status.reset_busy));
endmodule // frps_props

bind frps_sequencer frps_props #(
    .POWER_UP_CYCLES(POWER_UP_CYCLES),
    .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)
) u_frps_props (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .supply_good(supply_good),
    .chip_select_n(chip_select_n), .warm_reset_n(warm_reset_n), .serial_clk(serial_clk),
    .ops_pending(ops_pending), .init_ok(init_ok), .status(status),
    .reg_reset_pulse(reg_reset_pulse), .serial_clk_edge(serial_clk_edge)
);

// [bench/frps_host_model.sv]
// host model driving chip select and the serial clock
`timescale 1ns/1ps
module frps_host_model (
    // pins toward the device
    output logic chip_select_n,
    output logic serial_clk
);
    initial
    begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
    end
    task automatic select(input logic low);
        chip_select_n = !low;
    endtask
    // clock stands low outside frames; 8 MHz sits below every command limit
    task automatic frame(input int bits);
        chip_select_n = 1'b0;
        repeat (bits)
        begin
            // half periods land on core edges, so update after sampling
            #62.5 serial_clk <= 1'b1;
            #62.5 serial_clk <= 1'b0;
        end
        #62.5 chip_select_n <= 1'b1;
    endtask
endmodule // frps_host_model

// [bench/tb_flash_reset_power_sequencer.sv]
// self-checking bench of the flash reset and power sequencer
`timescale 1ns/1ps
module tb_flash_reset_power_sequencer;
    // short counts keep the run brief
    localparam int unsigned PU = 300;
    localparam int unsigned RH = 100;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic supply_good = 1'b0;
    logic warm_reset_n = 1'b0;
    logic ops_pending = 1'b0;
    logic init_ok = 1'b1;
    wire logic chip_select_n;
    wire logic serial_clk;
    frps_pkg::frps_status_s st;
    logic rrp;
    logic sce;
    int num_errors = 0;
    int total_checks = 0;
    int edges = 0;
    int aborts = 0;
    int pulses = 0;
    frps_sequencer #(.POWER_UP_CYCLES(PU), .RESET_HOLD_CYCLES(RH)) u_frps_sequencer (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .supply_good(supply_good),
        .chip_select_n(chip_select_n), .warm_reset_n(warm_reset_n), .serial_clk(serial_clk),
        .ops_pending(ops_pending), .init_ok(init_ok), .status(st),
        .reg_reset_pulse(rrp), .serial_clk_edge(sce));
    frps_host_model u_frps_host_model (.chip_select_n(chip_select_n), .serial_clk(serial_clk));
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        edges <= edges + int'(sce);
        aborts <= aborts + int'(st.abort_ops);
        pulses <= pulses + int'(rrp);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wait_idle(input int lim, output int n);
        n = 0;
        while (st.reset_busy !== 1'b0 && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    // reset held low through the end of power-up
    task automatic t_power_on;
        int n;
        cyc(PU + 20);
        check(16'(st.reset_busy), 16'h0001);
        check(16'(st.select_enable), 16'h0000);
        warm_reset_n = 1'b1;
        wait_idle(40, n);
        check(16'(n >= 10), 16'h0001);
        check(16'(st.standby_power), 16'h0001);
        check(16'(st.init_done), 16'h0001);
        $display("test power_on done");
    endtask
    task automatic t_active;
        int e;
        e = edges;
        ops_pending = 1'b1;
        fork
            u_frps_host_model.frame(8);
            begin
                cyc(20);
                check(16'({st.active_power, st.select_enable}), 16'h0003);
            end
        join
        cyc(10);
        check(16'(edges - e), 16'h0008);
        check(16'({st.active_power, st.standby_power}), 16'h0002);
        ops_pending = 1'b0;
        cyc(6);
        check(16'({st.active_power, st.standby_power}), 16'h0001);
        $display("test active done");
    endtask
    task automatic t_short;
        int a;
        int p;
        a = aborts;
        p = pulses;
        warm_reset_n = 1'b0;
        cyc(30);
        warm_reset_n = 1'b1;
        cyc(10);
        check(16'({st.reset_busy, 1'b0} | (aborts - a)), 16'h0000);
        check(16'(pulses - p), 16'h0000);
        $display("test short done");
    endtask
    task automatic t_warm;
        int a;
        int n;
        int p;
        a = aborts;
        p = pulses;
        u_frps_host_model.select(1'b1);
        cyc(5);
        warm_reset_n = 1'b0;
        cyc(50);
        check(16'({st.reset_busy, st.outputs_tristate, st.select_enable}), 16'h0006);
        check(16'(aborts - a), 16'h0001);
        check(16'(pulses - p), 16'h0001);
        check(16'(st.iface_to_standby), 16'h0001);
        u_frps_host_model.select(1'b0);
        cyc(10);
        warm_reset_n = 1'b1;
        cyc(RH - 65);
        check(16'(st.reset_busy), 16'h0001);
        wait_idle(60, n);
        check(16'({st.reset_busy, st.standby_power}), 16'h0001);
        check(16'(st.iface_to_standby), 16'h0000);
        $display("test warm done");
    endtask
    // frozen enable holds state through a supply drop; release restarts power-up
    task automatic t_freeze;
        int n;
        clk_en = 1'b0;
        supply_good = 1'b0;
        cyc(20);
        check(16'({st.reset_busy, st.standby_power, st.init_done}), 16'h0003);
        clk_en = 1'b1;
        cyc(5);
        check(16'({st.reset_busy, st.standby_power, st.init_done}), 16'h0004);
        supply_good = 1'b1;
        wait_idle(PU + 40, n);
        check(16'(n >= PU), 16'h0001);
        check(16'({st.standby_power, st.init_done}), 16'h0003);
        $display("test freeze done");
    endtask
    // failed init turns the next warm reset into a full power-up
    task automatic t_fail_init;
        int n;
        int p;
        p = pulses;
        resetn = 1'b0;
        init_ok = 1'b0;
        cyc(16);
        resetn = 1'b1;
        cyc(PU + 20);
        init_ok = 1'b1;
        warm_reset_n = 1'b0;
        cyc(50);
        warm_reset_n = 1'b1;
        wait_idle(PU + 200, n);
        check(16'(n + 50 >= PU), 16'h0001);
        check(16'(st.reset_busy), 16'h0000);
        check(16'(pulses - p), 16'h0000);
        $display("test fail_init done");
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        resetn = 1'b1;
        supply_good = 1'b1;
        t_power_on();
        t_active();
        t_short();
        t_warm();
        t_freeze();
        t_fail_init();
        final_report();
    end
    initial
    begin
        #50000;
        num_errors++;
        final_report();
    end
endmodule // tb_flash_reset_power_sequencer
